// ---- core/pptd_pkg.sv ----
// Package for the PWM generator with period update, trigger and dead time.
// Assumes a single 125 MHz clock domain and plain-port control.
package pptd_pkg;
    // Output mode field values (two bits)
    localparam logic [1:0] MODE_COMPLEMENTARY = 2'h0;
    localparam logic [1:0] MODE_REDUNDANT = 2'h1;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
    localparam logic [1:0] MODE_INDEPENDENT = 2'h3;
    // Field positions in the output control word
    localparam int OUT_MODE_HI = 11;
    localparam int OUT_MODE_LO = 10;
    // Field positions in the trigger control word
    localparam int TRG_DIV_HI = 15;
    localparam int TRG_DIV_LO = 12;
    localparam int TRG_STRT_HI = 5;
    localparam int TRG_STRT_LO = 0;
    // Reset values
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // Software-written configuration
    typedef struct packed {
        logic moduleEnable;
        logic immediatePeriodUpdateEn;
        logic centerAligned;
        logic swapOutputs;
        logic [15:0] outputControlReg;
        logic [15:0] triggerControlReg;
        logic [15:0] periodValue;
        logic [15:0] dutyValue;
        logic [15:0] phaseShiftValue;
        logic [15:0] specialEventCompare;
        logic [15:0] primaryTriggerCompare;
        logic [15:0] deadTime;
    } pptd_cfg_t;

    // Generator outputs
    typedef struct packed {
        logic highSideOutput;
        logic lowSideOutput;
        logic interruptReq;
        logic triggerOut;
        logic cycleStart;
    } pptd_out_t;
endpackage : pptd_pkg

// ---- core/pptd_generator.sv ----
// PWM generator: time base, period update, push-pull steering, trigger
// divider and postscaler start delay, dead-time insertion.
// Assumes configuration ports driven from logic on mclk (no synchroniser).
`timescale 1ns/1ps
`default_nettype none

module pptd_generator
    import pptd_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Configuration
    input wire pptd_pkg::pptd_cfg_t cfg,
    input wire logic periodWrite,
    // Outputs
    output var pptd_pkg::pptd_out_t pwmOut,
    output logic pushPullActive
);
    import pptd_pkg::*;

    // Whole module state
    typedef struct packed {
        logic [15:0] count;        // Time base counter
        logic countDown;           // Center-aligned direction
        logic [15:0] periodActive; // Period in use
        logic [15:0] periodPend;   // Period waiting for boundary
        logic pendValid;
        logic ppSide;              // 0 high side, 1 low side
        logic [3:0] divCnt;        // Trigger divider counter
        logic [5:0] strtCnt;       // Postscaler start delay
        logic strtDone;
        logic rawH;                // Undelayed high-side request
        logic [15:0] dtCnt;        // Dead time counter
        logic swapQ;               // Swap setting of the last cycle
        logic outH;
        logic outL;
        logic irq;
        logic trg;
        logic cyc;
        logic ppMode;
    } pptd_state_t;

    pptd_state_t s_q, s_d;

    logic [1:0] outMode;
    logic [3:0] trigger_output_divider;
    logic [5:0] postscaler_start_select;
    logic boundary;
    logic trigMatch;
    logic evtMatch;
    logic wantH;
    logic wantL;

    // Field extraction
    assign outMode = cfg.outputControlReg[OUT_MODE_HI:OUT_MODE_LO];
    assign trigger_output_divider = cfg.triggerControlReg[TRG_DIV_HI:TRG_DIV_LO];
    assign postscaler_start_select = cfg.triggerControlReg[TRG_STRT_HI:TRG_STRT_LO];

    // Boundary: edge-aligned at terminal count, center-aligned at the bottom
    assign boundary = cfg.centerAligned ? (s_q.countDown && s_q.count <= 16'h0001)
                                        : (s_q.count >= s_q.periodActive);
    // Compare matches are exact; no first-instance exception
    assign trigMatch = cfg.moduleEnable && s_q.count == cfg.primaryTriggerCompare;
    assign evtMatch = cfg.moduleEnable && s_q.count == cfg.specialEventCompare;

    // Next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.irq = trigMatch || evtMatch;
        s_d.trg = 1'b0;
        s_d.cyc = 1'b0;
        s_d.ppMode = outMode == MODE_PUSH_PULL;
        // Period write capture
        if (periodWrite)
        begin
            if (cfg.immediatePeriodUpdateEn)
            begin
                s_d.periodActive = cfg.periodValue;
                s_d.pendValid = 1'b0;
            end
            else
            begin
                s_d.periodPend = cfg.periodValue;
                s_d.pendValid = 1'b1;
            end
        end
        if (!cfg.moduleEnable)
        begin
            // Idle: clear counter, re-arm postscaler start delay
            s_d.count = COUNT_RST;
            s_d.countDown = 1'b0;
            s_d.ppSide = 1'b0;
            s_d.strtCnt = postscaler_start_select;
            s_d.strtDone = postscaler_start_select == 6'h00;
            s_d.divCnt = 4'h0;
            s_d.rawH = 1'b0;
        end
        else
        begin
            // Time base
            if (boundary)
            begin
                s_d.count = cfg.centerAligned ? 16'h0001 : COUNT_RST;
                s_d.countDown = 1'b0;
                s_d.cyc = 1'b1;
                // Steering flips only once per boundary, so in edge-aligned mode a period
                // change can never give one pin two pulses in a row
                s_d.ppSide = ~s_q.ppSide;
                if (s_q.pendValid && !(periodWrite && cfg.immediatePeriodUpdateEn))
                begin
                    s_d.periodActive = s_q.periodPend;
                    s_d.pendValid = periodWrite && !cfg.immediatePeriodUpdateEn;
                end
                // Postscaler start delay counts cycles
                if (!s_q.strtDone)
                begin
                    s_d.strtCnt = s_q.strtCnt - 6'h01;
                    s_d.strtDone = s_q.strtCnt <= 6'h01;
                end
            end
            else if (cfg.centerAligned && !s_q.countDown && s_q.count >= s_q.periodActive)
            begin
                s_d.countDown = 1'b1;
                s_d.count = s_q.count - 16'h0001;
            end
            else if (s_q.countDown)
            begin
                s_d.count = s_q.count - 16'h0001;
            end
            else
            begin
                s_d.count = s_q.count + 16'h0001;
            end
            // Trigger output divider: one output per trigger_output_divider+1 matches
            if (trigMatch && s_q.strtDone)
            begin
                if (s_q.divCnt >= trigger_output_divider)
                begin
                    s_d.divCnt = 4'h0;
                    s_d.trg = 1'b1;
                end
                else
                begin
                    s_d.divCnt = s_q.divCnt + 4'h1;
                end
            end
            // Raw duty request
            s_d.rawH = s_q.count < cfg.dutyValue;
        end
        // Dead time: restart whenever the raw request or the swap setting
        // changes; a swap change moves the active level to the other pin, so
        // it needs the same gap as a duty edge
        s_d.swapQ = cfg.swapOutputs;
        if (s_d.rawH != s_q.rawH || cfg.swapOutputs != s_q.swapQ)
        begin
            s_d.dtCnt = cfg.deadTime;
        end
        else if (s_q.dtCnt != 16'h0000)
        begin
            s_d.dtCnt = s_q.dtCnt - 16'h0001;
        end
        wantH = 1'b0;
        wantL = 1'b0;
        if (cfg.moduleEnable)
        begin
            case (outMode)
                MODE_PUSH_PULL:
                begin
                    wantH = s_q.rawH && !s_q.ppSide;
                    wantL = s_q.rawH && s_q.ppSide;
                end
                MODE_COMPLEMENTARY:
                begin
                    wantH = s_q.rawH && s_d.dtCnt == 16'h0000 && s_d.rawH == s_q.rawH;
                    wantL = !s_q.rawH && s_d.dtCnt == 16'h0000 && s_d.rawH == s_q.rawH;
                end
                MODE_REDUNDANT:
                begin
                    wantH = s_q.rawH;
                    wantL = s_q.rawH;
                end
                default:
                begin
                    wantH = s_q.rawH;
                    wantL = 1'b0;
                end
            endcase
        end
        // Swap relabels the pins after dead time
        s_d.outH = cfg.swapOutputs ? wantL : wantH;
        s_d.outL = cfg.swapOutputs ? wantH : wantL;
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.periodActive <= PERIOD_RST;
            s_q.strtDone <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign pwmOut.highSideOutput = s_q.outH;
    assign pwmOut.lowSideOutput = s_q.outL;
    assign pwmOut.interruptReq = s_q.irq;
    assign pwmOut.triggerOut = s_q.trg;
    assign pwmOut.cycleStart = s_q.cyc;
    assign pushPullActive = s_q.ppMode;

    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    pushpull_mode_a: assert property (outMode == MODE_PUSH_PULL |=> pushPullActive)
        else $error("push-pull mode not flagged");
    deferred_period_a: assert property (
        (periodWrite && !cfg.immediatePeriodUpdateEn && !boundary) |=> s_q.pendValid)
        else $error("deferred period not held pending");
    immediate_period_a: assert property (
        (periodWrite && cfg.immediatePeriodUpdateEn)
        |=> s_q.periodActive == $past(cfg.periodValue))
        else $error("immediate period not applied");
    // Disabling parks the side at high, so only running changes count
    no_double_a: assert property (
        (s_q.ppMode && $past(cfg.moduleEnable) && s_q.ppSide != $past(s_q.ppSide))
        |-> $past(boundary))
        else $error("push-pull side changed off boundary");
    irq_match_a: assert property ((trigMatch || evtMatch) |=> pwmOut.interruptReq)
        else $error("interrupt missed on compare match");
    trig_exact_a: assert property (pwmOut.triggerOut |-> $past(trigMatch))
        else $error("trigger away from compare value");
    div_zero_a: assert property (
        (trigMatch && s_q.strtDone && trigger_output_divider == 4'h0) |=> pwmOut.triggerOut)
        else $error("undivided trigger missing");
    start_gate_a: assert property (!s_q.strtDone |=> !pwmOut.triggerOut)
        else $error("trigger before postscaler start");
    dead_gap_a: assert property (
        (outMode == MODE_COMPLEMENTARY && !cfg.swapOutputs)
        |=> !(pwmOut.highSideOutput && pwmOut.lowSideOutput))
        else $error("both sides high in complementary");
    // Clearing swap must drop both sides the next cycle, not merely avoid overlap
    swap_clear_a: assert property (
        (cfg.moduleEnable && $fell(cfg.swapOutputs) && outMode == MODE_COMPLEMENTARY
        && cfg.deadTime != 16'h0000) |=> !(pwmOut.highSideOutput || pwmOut.lowSideOutput))
        else $error("no dead time after swap cleared");
    alternate_a: assert property (
        (cfg.moduleEnable && boundary) |=> s_q.ppSide != $past(s_q.ppSide))
        else $error("push-pull side did not alternate");

    cov_boundary_c: cover property (pwmOut.cycleStart);
    cov_trigger_c: cover property (pwmOut.triggerOut);
    cov_pushpull_c: cover property (pushPullActive && pwmOut.lowSideOutput);
    cov_swap_c: cover property ($fell(cfg.swapOutputs) && cfg.moduleEnable);

endmodule : pptd_generator
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the PWM generator, driving all ports directly.
// Assumes pptd_pkg and pptd_generator are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pptd_pkg::*;
    // Stimulus, outputs and monitor state
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic periodWrite = 1'b0;
    logic clr = 1'b0;
    logic hPrev = 1'b0;
    logic lPrev = 1'b0;
    pptd_cfg_t cfg = '0;
    pptd_out_t pwmOut;
    logic pushPullActive;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int nStart, nIrq, nTrg, trgStarts, trgMis, irqOfs, startCyc;
    int lowRun, lastFall, lastRise, gapBad, gapSeen, ppBad, nRise;

    pptd_generator dut (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg),
        .periodWrite(periodWrite), .pwmOut(pwmOut), .pushPullActive(pushPullActive));

    always #4 mclk = ~mclk;

    // Output watch; non-blocking so tasks see pre-edge counts
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        hPrev <= pwmOut.highSideOutput;
        lPrev <= pwmOut.lowSideOutput;
        if (clr)
        begin
            {nStart, nIrq, nTrg, trgStarts, trgMis, lowRun} <= '0;
            {lastFall, lastRise, gapBad, gapSeen, ppBad, nRise} <= '0;
        end
        else
        begin
            if (pwmOut.cycleStart)
            begin
                nStart <= nStart + 1;
                startCyc <= cyc;
            end
            if (pwmOut.interruptReq)
            begin
                nIrq <= nIrq + 1;
                irqOfs <= cyc - startCyc;
            end
            // Boundaries seen before the first trigger
            if (pwmOut.triggerOut)
                nTrg <= nTrg + 1;
            if (pwmOut.triggerOut && nTrg == 0)
                trgStarts <= nStart;
            // A trigger must land on its compare interrupt
            if (pwmOut.triggerOut && !pwmOut.interruptReq)
                trgMis <= trgMis + 1;
            // Dead-time gap: both-low run before the other side rises
            lowRun <= (pwmOut.highSideOutput || pwmOut.lowSideOutput) ? 0 : lowRun + 1;
            if (pwmOut.highSideOutput && pwmOut.lowSideOutput)
                gapBad <= gapBad + 1;
            // Any rise after a fall needs deadTime both-low cycles; this also
            // catches a swap that moves the level across pins in one step
            if (((pwmOut.highSideOutput && !hPrev) || (pwmOut.lowSideOutput && !lPrev))
                && lastFall != 0)
            begin
                gapSeen <= gapSeen + 1;
                if (lowRun < int'(cfg.deadTime))
                    gapBad <= gapBad + 1;
            end
            if (!pwmOut.highSideOutput && hPrev)
                lastFall <= 1;
            if (!pwmOut.lowSideOutput && lPrev)
                lastFall <= 2;
            // Push-pull: a pin must never pulse twice in a row
            if ((pwmOut.highSideOutput && !hPrev) || (pwmOut.lowSideOutput && !lPrev))
            begin
                nRise <= nRise + 1;
                ppBad <= ppBad + ((lastRise == (pwmOut.highSideOutput ? 1 : 2)) ? 1 : 0);
                lastRise <= pwmOut.highSideOutput ? 1 : 2;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Waits for the next boundary pulse, bounded
    task automatic wait_cs(output int t);
        int i;
        i = 0;
        @(posedge mclk);
        while (pwmOut.cycleStart !== 1'b1 && i < 3000)
        begin
            @(posedge mclk);
            i++;
        end
        t = cyc;
    endtask : wait_cs

    // Reprograms while disabled, then enables; counters clear at enable
    task automatic start(input logic [1:0] mode, input logic [15:0] per, trg, sev, tctl,
        input logic ca);
        @(posedge mclk);
        cfg.moduleEnable <= 1'b0;
        cfg.immediatePeriodUpdateEn <= 1'b1;
        cfg.outputControlReg[OUT_MODE_HI:OUT_MODE_LO] <= mode;
        cfg.centerAligned <= ca;
        cfg.periodValue <= per;
        cfg.dutyValue <= per >> 1;
        cfg.deadTime <= 16'h0003;
        cfg.phaseShiftValue <= 16'h0008;
        cfg.primaryTriggerCompare <= trg;
        cfg.specialEventCompare <= sev;
        cfg.triggerControlReg <= tctl;
        periodWrite <= 1'b1;
        clr <= 1'b1;
        @(posedge mclk);
        periodWrite <= 1'b0;
        @(posedge mclk);
        cfg.moduleEnable <= 1'b1;
        clr <= 1'b0;
    endtask : start

    task automatic t_mode();
        for (int m = 0; m < 4; m++)
        begin
            @(posedge mclk);
            cfg.outputControlReg[OUT_MODE_HI:OUT_MODE_LO] <= 2'(m);
            repeat (3) @(posedge mclk);
            chk({31'h0, pushPullActive}, {31'h0, m == 2});
        end
        $display("test mode done");
    endtask : t_mode

    // Period 20 then a write of 8 early in a cycle
    task automatic t_period(input logic imm);
        int t0, t1, t2;
        start(MODE_COMPLEMENTARY, 16'h0014, 16'hff00, 16'hff00, 16'h0000, 1'b0);
        cfg.immediatePeriodUpdateEn <= imm;
        wait_cs(t0);
        wait_cs(t0);
        repeat (2) @(posedge mclk);
        cfg.periodValue <= 16'h0008;
        periodWrite <= 1'b1;
        @(posedge mclk);
        periodWrite <= 1'b0;
        wait_cs(t1);
        wait_cs(t2);
        chk(32'(t1 - t0), imm ? 32'd9 : 32'd21);
        chk(32'(t2 - t1), 32'd9);
        $display("test period imm=%0d done", imm);
    endtask : t_period

    // Period writes landing on the rollover edge, deferred then immediate
    task automatic t_pp();
        int t;
        int per;
        per = 12;
        start(MODE_PUSH_PULL, 16'h000c, 16'hff00, 16'hff00, 16'h0000, 1'b0);
        cfg.immediatePeriodUpdateEn <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            // Rollover falls per edges after the cycle-start pulse is seen
            repeat (4) wait_cs(t);
            repeat (per - 1) @(posedge mclk);
            cfg.immediatePeriodUpdateEn <= (k == 1);
            cfg.periodValue <= 16'h0009 + 16'(k);
            periodWrite <= (k < 2);
            @(posedge mclk);
            periodWrite <= 1'b0;
            per = 9 + k;
        end
        chk(ppBad, 0);
        chk(32'(nRise > 8), 1);
        $display("test push-pull done");
    endtask : t_pp

    // Dividers 0, 5, 10, 15 with compare 8; then special event at 5
    task automatic t_trig();
        int t, ofsT;
        for (int d = 0; d < 16; d += 5)
        begin
            start(MODE_COMPLEMENTARY, 16'h0009, 16'h0008, 16'hff00, {4'(d), 12'h000}, 1'b0);
            repeat (2 * (d + 1)) wait_cs(t);
            chk(nIrq, 2 * (d + 1));
            chk(nTrg, 2);
            chk(trgMis, 0);
            if (d == 0)
                ofsT = irqOfs;
        end
        start(MODE_COMPLEMENTARY, 16'h0009, 16'hff00, 16'h0005, 16'h0000, 1'b0);
        repeat (3) wait_cs(t);
        chk(nIrq, 3);
        // Offset difference is the distance between the two compare values
        chk(32'(irqOfs - ofsT), 32'(5 - 8));
        start(MODE_COMPLEMENTARY, 16'h0009, 16'h0003, 16'hff00, 16'h0003, 1'b0);
        repeat (5) wait_cs(t);
        chk(trgStarts, 3);
        chk(nTrg, 2);
        $display("test trigger done");
    endtask : t_trig

    // Center-aligned complementary, swap set then cleared while running
    task automatic t_dead();
        int t;
        cfg.swapOutputs <= 1'b1;
        start(MODE_COMPLEMENTARY, 16'h0014, 16'hff00, 16'hff00, 16'h0000, 1'b1);
        repeat (3) wait_cs(t);
        cfg.swapOutputs <= 1'b0;
        repeat (3) wait_cs(t);
        chk(gapBad, 0);
        chk(32'(gapSeen > 4), 1);
        $display("test dead time done");
    endtask : t_dead

    task automatic close_out();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (8) @(posedge mclk);
        chk({27'h0, pwmOut}, 32'h0);
        chk({31'h0, pushPullActive}, 32'h0);
        sys_rst <= 1'b0;
        fork
            begin
                t_mode();
                t_period(1'b0);
                t_period(1'b1);
                t_pp();
                t_trig();
                t_dead();
            end
            begin
                // Tests need about 1,350 cycles; a hang stops here
                wait (cyc >= 5000);
                errors++;
                $display("timeout at t=%0t", $time);
            end
        join_any
        close_out();
    end
endmodule : tb_top
`default_nettype wire
